// File: logic/blc_map.svh
`ifndef BLC_MAP_SVH
`define BLC_MAP_SVH

// Register byte offsets
`define BLC_OFS_DELAY 32'h0000_0000
`define BLC_OFS_CTL1 32'h0000_0004
`define BLC_OFS_CTL2 32'h0000_0008
`define BLC_OFS_STAT 32'h0000_000C

// Reset values
`define BLC_RST_DELAY 4'h7
`define BLC_RST_CTL1 8'h80
`define BLC_RST_CTL2 8'h40

// Field positions
`define BLC_DLY_MSB 3
`define BLC_C1_WCM 0
`define BLC_C1_IE 1
`define BLC_C1_RLO 2
`define BLC_C1_RHI 3
`define BLC_C1_TB 4
`define BLC_C1_IGN 7
`define BLC_C2_ANALOG_LOOPBACK 6
`define BLC_ST_IGN 0
`define BLC_ST_DLK 1
`define BLC_ST_RLK 2
`define BLC_ST_RXOK 3
`define BLC_ST_TXOK 4

// Timing, one link tick is nominally one microsecond
`define BLC_DLY_BASE_US 9
`define BLC_BIN_SCALE 1074
`define BLC_EOF_US 280
`define BLC_IFS_US 300
`define BLC_EOF_TK_INT (`BLC_EOF_US)
`define BLC_IFS_TK_INT (`BLC_IFS_US)
`define BLC_EOF_TK_BIN ((`BLC_EOF_US * `BLC_BIN_SCALE) / 1024)
`define BLC_IFS_TK_BIN ((`BLC_IFS_US * `BLC_BIN_SCALE) / 1024)

// Bus answers and pin level
`define BLC_RESP_OKAY 2'b00
`define BLC_RESP_DECERR 2'b11
`define BLC_RX_PASSIVE 1'b0

`endif

// File: logic/blc_pkg.sv
package blc_pkg;

    typedef logic [1:0] blc_rate_t;

    typedef struct packed {
        logic ignore_message;
        logic timebase_select;
        blc_rate_t rate_select;
        logic interrupt_gate;
        logic wait_clock_stop;
    } blc_ctl1_t;

    typedef enum logic [1:0] {
        BLC_LS_LOOP = 2'b00,
        BLC_LS_WAIT = 2'b01,
        BLC_LS_RXOK = 2'b10,
        BLC_LS_READY = 2'b11
    } blc_link_st_t;

endpackage : blc_pkg

// File: logic/blc_rate_div.sv
`timescale 1ns/10ps

module blc_rate_div
    import blc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Divide code
    input wire blc_rate_t i_rate,
    // Link timebase enable
    output logic o_tick
);

    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;
    logic [2:0] last;

    // Divide by 1, 2, 4, 8
    always_comb begin
        last = (3'b001 << i_rate) - 3'b001;
        nxt_tick = (cnt_ff == last);
        nxt_cnt = (cnt_ff >= last) ? 3'b000 : cnt_ff + 3'b001;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= 3'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign o_tick = tick_ff;

endmodule : blc_rate_div

// File: logic/blc_regs.sv
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "blc_map.svh"

module blc_regs
    import blc_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // AXI4-Lite write
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Transceiver pin and link engine
    input wire logic i_rx_pin,
    input wire logic i_sof_det,
    input wire logic i_break_det,
    input wire logic i_irq_src,
    input wire logic i_wake_req,
    input wire logic i_cpu_wait,
    // Link controls
    output logic o_irq,
    output logic o_rx_ignore,
    output logic o_link_tick,
    output logic o_timebase,
    output logic [4:0] o_delay_ticks,
    output logic o_clk_run,
    output logic o_loop_sel,
    output logic o_tx_drive_en,
    output logic o_sm_reset,
    output logic o_rx_permit,
    output logic o_tx_permit
);

    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_ff[1];

    // Bus slave
    logic aw_full_ff, nxt_aw_full;
    logic w_full_ff, nxt_w_full;
    logic [31:0] awaddr_ff, nxt_awaddr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic wstb_ff, nxt_wstb;
    logic awready_ff, nxt_awready;
    logic wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic arready_ff, nxt_arready;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic wr_do;
    logic wr_hit;
    logic [31:0] wr_adr;
    logic [31:0] rd_adr;
    logic [31:0] rd_mux;
    logic rd_hit;

    // Register state
    logic [3:0] dly_ff, nxt_dly;
    logic dlk_ff, nxt_dlk;
    logic rlk_ff, nxt_rlk;
    blc_ctl1_t ctl1_ff, nxt_ctl1;
    logic analog_loopback_ff, nxt_analog_loopback;
    logic wsel_dly, wsel_c1, wsel_c2;
    localparam logic [7:0] rst_ctl1_img = `BLC_RST_CTL1;
    localparam logic [7:0] rst_ctl2_img = `BLC_RST_CTL2;

    // Link state
    logic [2:0] rx_sync_ff, nxt_rx_sync;
    logic rx_lvl_ff, nxt_rx_lvl;
    blc_link_st_t lst_ff, nxt_lst;
    logic [8:0] idle_ff, nxt_idle;
    logic irq_ff, nxt_irq;
    logic clk_run_ff, nxt_clk_run;
    logic drive_ff, nxt_drive;
    logic smrst_ff, nxt_smrst;
    logic [4:0] dtk_ff, nxt_dtk;
    logic [8:0] eof_lim, ifs_lim;
    logic [4:0] dly_us;
    logic [15:0] dly_prod;
    logic link_tick;

    always_comb begin
        wr_adr = {awaddr_ff[31:2], 2'b00};
        rd_adr = {i_araddr[31:2], 2'b00};
        wr_hit = (wr_adr == `BLC_OFS_DELAY) || (wr_adr == `BLC_OFS_CTL1)
            || (wr_adr == `BLC_OFS_CTL2) || (wr_adr == `BLC_OFS_STAT);
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (rd_adr)
            `BLC_OFS_DELAY: rd_mux[`BLC_DLY_MSB:0] = dly_ff;
            `BLC_OFS_CTL1: begin
                rd_mux[`BLC_C1_WCM] = ctl1_ff.wait_clock_stop;
                rd_mux[`BLC_C1_IE] = ctl1_ff.interrupt_gate;
                rd_mux[`BLC_C1_RLO] = ctl1_ff.rate_select[0];
                rd_mux[`BLC_C1_RHI] = ctl1_ff.rate_select[1];
                rd_mux[`BLC_C1_TB] = ctl1_ff.timebase_select;
                rd_mux[`BLC_C1_IGN] = ctl1_ff.ignore_message;
            end
            `BLC_OFS_CTL2: rd_mux[`BLC_C2_ANALOG_LOOPBACK] = analog_loopback_ff;
            `BLC_OFS_STAT: begin
                rd_mux[`BLC_ST_IGN] = ctl1_ff.ignore_message;
                rd_mux[`BLC_ST_DLK] = dlk_ff;
                rd_mux[`BLC_ST_RLK] = rlk_ff;
                rd_mux[`BLC_ST_RXOK] = o_rx_permit;
                rd_mux[`BLC_ST_TXOK] = o_tx_permit;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        nxt_aw_full = aw_full_ff;
        nxt_w_full = w_full_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstb = wstb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        // Both halves held and no answer pending
        wr_do = aw_full_ff && w_full_ff && !bvalid_ff;
        if (bvalid_ff && i_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (wr_do) begin
            nxt_aw_full = 1'b0;
            nxt_w_full = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_hit ? `BLC_RESP_OKAY : `BLC_RESP_DECERR;
        end
        if (i_awvalid && awready_ff) begin
            nxt_aw_full = 1'b1;
            nxt_awaddr = i_awaddr;
        end
        if (i_wvalid && wready_ff) begin
            nxt_w_full = 1'b1;
            nxt_wdata = i_wdata[7:0];
            nxt_wstb = i_wstrb[0];
        end
        if (rvalid_ff && i_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (i_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_mux;
            nxt_rresp = rd_hit ? `BLC_RESP_OKAY : `BLC_RESP_DECERR;
        end
        nxt_awready = !nxt_aw_full;
        nxt_wready = !nxt_w_full;
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awaddr_ff <= 32'h0000_0000;
            wdata_ff <= 8'h00;
            wstb_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'b00;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'b00;
        end else begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff <= nxt_w_full;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstb_ff <= nxt_wstb;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign o_awready = awready_ff;
    assign o_wready = wready_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;

    always_comb begin
        wsel_dly = wr_do && wstb_ff && (wr_adr == `BLC_OFS_DELAY);
        wsel_c1 = wr_do && wstb_ff && (wr_adr == `BLC_OFS_CTL1);
        wsel_c2 = wr_do && wstb_ff && (wr_adr == `BLC_OFS_CTL2);
        nxt_dly = dly_ff;
        nxt_dlk = dlk_ff;
        nxt_rlk = rlk_ff;
        nxt_ctl1 = ctl1_ff;
        nxt_analog_loopback = analog_loopback_ff;
        if (wsel_dly && !dlk_ff) begin
            nxt_dly = wdata_ff[`BLC_DLY_MSB:0];
            nxt_dlk = 1'b1;
        end
        if (i_sof_det || i_break_det) begin
            nxt_ctl1.ignore_message = 1'b0;
        end
        if (wsel_c1) begin
            nxt_ctl1.wait_clock_stop = wdata_ff[`BLC_C1_WCM];
            nxt_ctl1.interrupt_gate = wdata_ff[`BLC_C1_IE];
            nxt_ctl1.timebase_select = wdata_ff[`BLC_C1_TB];
            nxt_ctl1.ignore_message = wdata_ff[`BLC_C1_IGN];
            if (!rlk_ff) begin
                nxt_ctl1.rate_select = {wdata_ff[`BLC_C1_RHI], wdata_ff[`BLC_C1_RLO]};
                nxt_rlk = 1'b1;
            end
        end
        if (wsel_c2) begin
            nxt_analog_loopback = wdata_ff[`BLC_C2_ANALOG_LOOPBACK];
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            dly_ff <= `BLC_RST_DELAY;
            dlk_ff <= 1'b0;
            rlk_ff <= 1'b0;
            ctl1_ff <= blc_ctl1_t'({rst_ctl1_img[`BLC_C1_IGN], rst_ctl1_img[`BLC_C1_TB:0]});
            analog_loopback_ff <= rst_ctl2_img[`BLC_C2_ANALOG_LOOPBACK];
        end else begin
            dly_ff <= nxt_dly;
            dlk_ff <= nxt_dlk;
            rlk_ff <= nxt_rlk;
            ctl1_ff <= nxt_ctl1;
            analog_loopback_ff <= nxt_analog_loopback;
        end
    end

    blc_rate_div u_rate_div (
        .i_clk(i_mclk),
        .i_rst_n(rst_n),
        .i_rate(ctl1_ff.rate_select),
        .o_tick(link_tick)
    );

    always_comb begin
        nxt_rx_sync = {rx_sync_ff[1:0], i_rx_pin};
        nxt_rx_lvl = rx_lvl_ff;
        // Filter: second and third stage agree
        if (rx_sync_ff[1] == rx_sync_ff[2]) begin
            nxt_rx_lvl = rx_sync_ff[2];
        end
        eof_lim = ctl1_ff.timebase_select ? 9'(`BLC_EOF_TK_BIN) : 9'(`BLC_EOF_TK_INT);
        ifs_lim = ctl1_ff.timebase_select ? 9'(`BLC_IFS_TK_BIN) : 9'(`BLC_IFS_TK_INT);
        dly_us = 5'(`BLC_DLY_BASE_US) + {1'b0, dly_ff};
        dly_prod = 16'(dly_us) * 16'(`BLC_BIN_SCALE);
        nxt_dtk = ctl1_ff.timebase_select ? dly_prod[14:10] : dly_us;
        nxt_idle = idle_ff;
        if (analog_loopback_ff || rx_lvl_ff != `BLC_RX_PASSIVE) begin
            nxt_idle = 9'h000;
        end else if (link_tick && idle_ff < ifs_lim) begin
            nxt_idle = idle_ff + 9'h001;
        end
        nxt_lst = lst_ff;
        case (lst_ff)
            BLC_LS_LOOP: if (!analog_loopback_ff) nxt_lst = BLC_LS_WAIT;
            BLC_LS_WAIT: if (idle_ff >= eof_lim) nxt_lst = BLC_LS_RXOK;
            BLC_LS_RXOK: if (idle_ff >= ifs_lim) nxt_lst = BLC_LS_READY;
            BLC_LS_READY: nxt_lst = BLC_LS_READY;
            default: nxt_lst = BLC_LS_LOOP;
        endcase
        if (analog_loopback_ff) begin
            nxt_lst = BLC_LS_LOOP;
        end
        nxt_irq = !ctl1_ff.ignore_message
            && ((ctl1_ff.interrupt_gate && i_irq_src) || i_wake_req);
        nxt_clk_run = !(ctl1_ff.wait_clock_stop && i_cpu_wait);
        nxt_drive = !analog_loopback_ff;
        nxt_smrst = nxt_analog_loopback && !analog_loopback_ff;
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_ff <= 3'h0;
            rx_lvl_ff <= 1'b0;
            lst_ff <= BLC_LS_LOOP;
            idle_ff <= 9'h000;
            irq_ff <= 1'b0;
            clk_run_ff <= 1'b1;
            drive_ff <= 1'b0;
            smrst_ff <= 1'b0;
            dtk_ff <= 5'h00;
        end else begin
            rx_sync_ff <= nxt_rx_sync;
            rx_lvl_ff <= nxt_rx_lvl;
            lst_ff <= nxt_lst;
            idle_ff <= nxt_idle;
            irq_ff <= nxt_irq;
            clk_run_ff <= nxt_clk_run;
            drive_ff <= nxt_drive;
            smrst_ff <= nxt_smrst;
            dtk_ff <= nxt_dtk;
        end
    end

    assign o_irq = irq_ff;
    assign o_rx_ignore = ctl1_ff.ignore_message;
    assign o_link_tick = link_tick;
    assign o_timebase = ctl1_ff.timebase_select;
    assign o_delay_ticks = dtk_ff;
    assign o_clk_run = clk_run_ff;
    assign o_loop_sel = analog_loopback_ff;
    assign o_tx_drive_en = drive_ff;
    assign o_sm_reset = smrst_ff;
    assign o_rx_permit = (lst_ff == BLC_LS_RXOK) || (lst_ff == BLC_LS_READY);
    assign o_tx_permit = (lst_ff == BLC_LS_READY);

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    dly_lock_hold_a: assert property (dlk_ff |=> $stable(dly_ff) && dlk_ff)
        else $error("Delay code changed after lock");

    rate_lock_hold_a: assert property (rlk_ff |=> $stable(ctl1_ff.rate_select) && rlk_ff)
        else $error("Rate select changed after lock");

    ignore_mask_a: assert property (ctl1_ff.ignore_message |=> !o_irq)
        else $error("Interrupt raised while ignoring");

    ignore_clear_a: assert property ((i_sof_det || i_break_det) && !wsel_c1 |=> !o_rx_ignore)
        else $error("Ignore not cleared by frame start");

    irq_level_a: assert property (!ctl1_ff.ignore_message && ctl1_ff.interrupt_gate && i_irq_src |=> o_irq)
        else $error("Active source without interrupt");

    irq_gate_a: assert property (!ctl1_ff.interrupt_gate && !i_wake_req |=> !o_irq)
        else $error("Interrupt passed a closed gate");

    wake_pass_a: assert property (!ctl1_ff.ignore_message && i_wake_req |=> o_irq)
        else $error("Wake-up request was gated");

    tick_div8_a: assert property (link_tick && rlk_ff && ctl1_ff.rate_select == 2'h3
        |=> !link_tick [*7] ##1 link_tick)
        else $error("Divide by eight spacing wrong");

    // Tick copy lags the code by one cycle and sits at zero in reset
    delay_int_a: assert property (rst_n && !ctl1_ff.timebase_select
        |=> o_delay_ticks == 5'($past(dly_ff)) + 5'h09)
        else $error("Delay ticks do not match code");
    loop_undriven_a: assert property (analog_loopback_ff |=> !o_tx_drive_en && !o_rx_permit)
        else $error("Bus driven during loopback");

    loop_reset_a: assert property ($rose(analog_loopback_ff) |-> o_sm_reset ##1 !o_sm_reset)
        else $error("Loopback entry gave no single reset pulse");

    tx_after_eof_a: assert property ($rose(o_tx_permit) |-> $past(o_rx_permit))
        else $error("Transmit allowed before end-of-frame");

    rx_idle_a: assert property ($rose(o_rx_permit) |-> $past(idle_ff) >= $past(eof_lim))
        else $error("Receive allowed before idle time");

    wait_clock_a: assert property (ctl1_ff.wait_clock_stop && i_cpu_wait |=> !o_clk_run)
        else $error("Clocks kept running in wait");

    ignore_resume_c: cover property (o_rx_ignore ##1 !o_rx_ignore ##1 o_irq);
    loop_exit_c: cover property ($fell(analog_loopback_ff) ##[1:1000] o_tx_permit);
    delay_write_c: cover property (wsel_dly && !dlk_ff ##1 dlk_ff);
    dly_relock_c: cover property (wsel_dly && dlk_ff);

endmodule : blc_regs

// File: tb/blc_xcvr_model.sv
`timescale 1ns/10ps

module blc_xcvr_model (
    // Clock
    input wire logic i_clk,
    // Commands from the bench
    input wire logic i_act,
    input wire logic i_sof,
    input wire logic i_brk,
    // Toward the controller
    output logic o_rx_pin,
    output logic o_sof_det,
    output logic o_brk_det
);
    // Bus idles at its passive level, never a stale active value
    initial begin
        o_rx_pin = 1'b0;
        o_sof_det = 1'b0;
        o_brk_det = 1'b0;
    end

    // One cycle of transceiver latency on every path
    always @(posedge i_clk) begin
        o_rx_pin <= i_act;
        o_sof_det <= i_sof;
        o_brk_det <= i_brk;
    end
endmodule : blc_xcvr_model

// File: tb/tb_j1850_link_config_regs.sv
`timescale 1ns/10ps
`include "blc_map.svh"

module tb_j1850_link_config_regs;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, act, sof, brk, src, wake, cwait;
    logic [31:0] awaddr, wdata, araddr, rdata, rdv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic awready, wready, bvalid, arready, rvalid, rx_pin, sof_d, brk_d, irq, ign, tick, tbase;
    logic clk_run, loop_sel, drv_en, sm_rst, rx_ok, tx_ok, sm_seen;
    logic [4:0] dly;
    int mismatches, total_checks, cyc, n;

    blc_regs DUT (.i_mclk(clk), .i_reset_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_rx_pin(rx_pin), .i_sof_det(sof_d), .i_break_det(brk_d), .i_irq_src(src), .i_wake_req(wake),
        .i_cpu_wait(cwait), .o_irq(irq), .o_rx_ignore(ign), .o_link_tick(tick), .o_timebase(tbase),
        .o_delay_ticks(dly), .o_clk_run(clk_run), .o_loop_sel(loop_sel), .o_tx_drive_en(drv_en),
        .o_sm_reset(sm_rst), .o_rx_permit(rx_ok), .o_tx_permit(tx_ok));

    blc_xcvr_model u_xcvr (.i_clk(clk), .i_act(act), .i_sof(sof), .i_brk(brk), .o_rx_pin(rx_pin),
        .o_sof_det(sof_d), .o_brk_det(brk_d));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard, also catches the one-cycle engine reset pulse
    always @(negedge clk) begin
        cyc++;
        if (sm_rst === 1'b1) sm_seen = 1'b1;
        if (cyc == 5000) begin
            mismatches++;
            report_and_stop;
        end
    end

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            // Ready is stable from here to the sampling edge
            @(negedge clk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge clk);
            ha = arvalid & arready;
            hr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
        end
    endtask : rd

    task automatic wrc(input logic [31:0] a, input logic [7:0] d);
        wr(a, d, rsp);
        chk(32'(rsp), 32'(`BLC_RESP_OKAY));
    endtask : wrc

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        rd(a, rdv, rsp);
        chk(32'(rsp), 32'(`BLC_RESP_OKAY));
        chk(rdv, exp);
    endtask : rdc

    task automatic settle;
        repeat (4) @(negedge clk);
    endtask : settle

    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : do_reset

    task automatic period(output int p);
        p = 0;
        @(negedge clk);
        while (tick !== 1'b1) @(negedge clk);
        do begin
            @(negedge clk);
            p++;
        end while (tick !== 1'b1);
    endtask : period

    initial begin
        mismatches = 0;
        total_checks = 0;
        cyc = 0;
        sm_seen = 1'b0;
        {rst_n, awvalid, wvalid, bready, arvalid, rready, act, sof, brk, src, wake, cwait} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        do_reset;
        rdc(`BLC_OFS_DELAY, 32'h0000_0007);
        rdc(`BLC_OFS_CTL1, 32'h0000_0080);
        rdc(`BLC_OFS_CTL2, 32'h0000_0040);
        rdc(`BLC_OFS_STAT, 32'h0000_0001);
        chk(32'(dly), 32'd16);
        chk({loop_sel, drv_en}, 32'h0000_0002);
        rd(32'h0000_0010, rdv, rsp);
        chk(32'(rsp), 32'(`BLC_RESP_DECERR));
        wr(32'h0000_0014, 8'h0F, rsp);
        chk(32'(rsp), 32'(`BLC_RESP_DECERR));
        for (int c = 3; c >= 0; c--) begin
            do_reset;
            // Software picks the rate code for its clock
            wrc(`BLC_OFS_CTL1, 8'(c << 2));
            period(n);
            chk(32'(n), 32'(1 << c));
            wrc(`BLC_OFS_CTL1, 8'h0C ^ 8'(c << 2));
            rdc(`BLC_OFS_CTL1, 32'(c << 2));
        end
        wrc(`BLC_OFS_DELAY, 8'h0F);
        settle;
        chk(32'(dly), 32'd24);
        wrc(`BLC_OFS_DELAY, 8'h00);
        rdc(`BLC_OFS_DELAY, 32'h0000_000F);
        chk(32'(dly), 32'd24);
        rdc(`BLC_OFS_STAT, 32'h0000_0006);
        wrc(`BLC_OFS_CTL1, 8'h10);
        settle;
        chk(32'(tbase), 32'h0000_0001);
        chk(32'(dly), (32'd24 * `BLC_BIN_SCALE) / 1024);
        wrc(`BLC_OFS_CTL1, 8'h02);
        @(posedge clk) src <= 1'b1;
        settle;
        chk(32'(irq), 32'h0000_0001);
        repeat (6) @(negedge clk);
        chk(32'(irq), 32'h0000_0001);
        wrc(`BLC_OFS_CTL1, 8'h00);
        settle;
        chk(32'(irq), 32'h0000_0000);
        @(posedge clk) wake <= 1'b1;
        settle;
        chk(32'(irq), 32'h0000_0001);
        @(posedge clk) wake <= 1'b0;
        wrc(`BLC_OFS_CTL1, 8'h82);
        settle;
        chk(32'(irq), 32'h0000_0000);
        chk(32'(ign), 32'h0000_0001);
        @(posedge clk) sof <= 1'b1;
        @(posedge clk) sof <= 1'b0;
        settle;
        chk(32'(ign), 32'h0000_0000);
        chk(32'(irq), 32'h0000_0001);
        rdc(`BLC_OFS_CTL1, 32'h0000_0002);
        wrc(`BLC_OFS_CTL1, 8'h82);
        @(posedge clk) brk <= 1'b1;
        @(posedge clk) brk <= 1'b0;
        settle;
        chk(32'(ign), 32'h0000_0000);
        @(posedge clk) src <= 1'b0;
        settle;
        chk(32'(irq), 32'h0000_0000);
        wrc(`BLC_OFS_CTL1, 8'h01);
        @(posedge clk) cwait <= 1'b1;
        settle;
        chk(32'(clk_run), 32'h0000_0000);
        wrc(`BLC_OFS_CTL1, 8'h00);
        settle;
        chk(32'(clk_run), 32'h0000_0001);
        @(posedge clk) cwait <= 1'b0;
        // Bus busy while loopback is released
        @(posedge clk) act <= 1'b1;
        // Only the loopback bit changes in control two
        wrc(`BLC_OFS_CTL2, 8'h00);
        settle;
        chk({loop_sel, drv_en}, 32'h0000_0001);
        repeat (40) @(negedge clk);
        chk(32'(rx_ok), 32'h0000_0000);
        @(posedge clk) act <= 1'b0;
        n = 0;
        while (rx_ok !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(32'(n >= 280 && n <= 295 && tx_ok === 1'b0), 32'h0000_0001);
        while (tx_ok !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(32'(n >= 300 && n <= 315), 32'h0000_0001);
        sm_seen = 1'b0;
        wrc(`BLC_OFS_CTL2, 8'h40);
        settle;
        chk(32'(sm_seen), 32'h0000_0001);
        chk({rx_ok, tx_ok, drv_en}, 32'h0000_0000);
        // Binary timebase stretches both idle limits
        wrc(`BLC_OFS_CTL1, 8'h10);
        wrc(`BLC_OFS_CTL2, 8'h00);
        n = 0;
        while (rx_ok !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(32'(n >= `BLC_EOF_TK_BIN && n <= `BLC_EOF_TK_BIN + 8 && tx_ok === 1'b0), 32'h0000_0001);
        while (tx_ok !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(32'(n >= `BLC_IFS_TK_BIN && n <= `BLC_IFS_TK_BIN + 8), 32'h0000_0001);
        report_and_stop;
    end
endmodule : tb_j1850_link_config_regs
